// File: reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module reset_ctrl #(
    parameter int POWERUP_TIMER_COUNT   = reset_pkg::POWERUP_TIMER_CYCLES,
    parameter int FILTER_COUNT = reset_pkg::PIN_FILTER_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [1:0]  BROWNOUT_MODE_CFG,
    input  wire logic        LOW_POWER_BROWNOUT_CFG_N,
    input  wire logic        MASTER_CLEAR_ENABLE_CFG,
    input  wire logic        LOW_VOLTAGE_PROGRAM_CFG,
    input  wire logic        POWERUP_TIMER_ENABLE_N,
    input  wire logic        STACK_RESET_ENABLE_CFG,
    input  wire logic        SUPPLY_LOW,
    input  wire logic        LP_SUPPLY_LOW,
    input  wire logic        DETECTOR_READY,
    input  wire logic        MASTER_CLEAR_PIN_IN,
    input  wire logic        PIN_PULLUP_SW,
    input  wire logic        PROG_MODE,
    input  wire logic        SLEEPING,
    input  wire logic        WAKE_WATCHDOG,
    input  wire logic        WAKE_IRQ,
    input  wire logic        GLOBAL_IRQ_ENABLE,
    input  wire logic        WATCHDOG_OVERFLOW,
    input  wire logic        WATCHDOG_WINDOW,
    input  wire logic        RESET_INSTR,
    input  wire logic        STACK_OVER,
    input  wire logic        STACK_UNDER,
    input  wire logic [14:0] PC_CURRENT,
    input  wire logic [1:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [7:0]       RDATA,
    output logic             CORE_RESET,
    output logic             DETECTOR_ENABLE,
    output logic             BANDGAP_FORCE_ON,
    output logic             WAKE_HOLD,
    output logic             PIN_GPIO_IN,
    output logic             PIN_PULLUP_EN,
    output logic             PC_LOAD,
    output logic [14:0]      PC_VALUE
);
    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // The glitch filter counter is eight bits wide.
    if (POWERUP_TIMER_COUNT < 1 || FILTER_COUNT < 1 || FILTER_COUNT > 255) begin : g_bad
        $error("Counts must be at least one.");
    end

    typedef enum logic [3:0] {
        ST_HOLD  = 4'b0001,
        ST_POWERUP_TIMER  = 4'b0010,
        ST_START = 4'b0100,
        ST_RUN   = 4'b1000
    } seq_e;

    seq_e        state_q;
    logic [31:0] cnt_q;
    logic        sw_en_q;
    logic        fast_q;
    logic [7:0]  power_control_q;
    logic [1:0]  status_q;
    logic [7:0]  filt_q;
    logic        pin_low_q;
    logic        pin_en;
    logic        mode_sw;
    logic        det_on;
    logic        bo_trip;
    logic        lp_trip;
    logic        por_evt;
    logic        pin_evt;
    logic        core_evt;
    logic        wait_ready;

    // ****************************************************************
    // Detector control
    // ****************************************************************
    assign mode_sw = BROWNOUT_MODE_CFG == reset_pkg::MODE_SOFTWARE;
    assign pin_en  = MASTER_CLEAR_ENABLE_CFG | LOW_VOLTAGE_PROGRAM_CFG; // RULE11
    always_comb begin
        unique case (BROWNOUT_MODE_CFG)
            reset_pkg::MODE_ALWAYS_ON: det_on = 1'b1; // RULE24
            reset_pkg::MODE_SLEEP_OFF: det_on = !SLEEPING; // RULE1
            reset_pkg::MODE_SOFTWARE:  det_on = sw_en_q; // RULE5 RULE6
            default:                   det_on = 1'b0;
        endcase
    end
    // Brownout protection only counts once the analog circuit reports ready; the low-power trip does not wait for it.
    assign bo_trip  = det_on & DETECTOR_READY & SUPPLY_LOW; // RULE4
    assign lp_trip  = !LOW_POWER_BROWNOUT_CFG_N & LP_SUPPLY_LOW; // RULE9 RULE10
    assign por_evt  = PROG_MODE; // RULE17
    assign pin_evt  = pin_en & pin_low_q; // RULE12
    assign core_evt = RESET_INSTR | WATCHDOG_OVERFLOW | WATCHDOG_WINDOW
                    | (STACK_RESET_ENABLE_CFG & (STACK_OVER | STACK_UNDER)); // RULE16
    // Modes 11 and 10 wait for readiness; mode 01 never does.
    assign wait_ready = (BROWNOUT_MODE_CFG == reset_pkg::MODE_ALWAYS_ON)
                      | (BROWNOUT_MODE_CFG == reset_pkg::MODE_SLEEP_OFF); // RULE3

    // ****************************************************************
    // Pin filter
    // ****************************************************************
    // A low must persist for the filter length; shorter glitches are ignored.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            filt_q    <= 8'h00;
            pin_low_q <= 1'b0;
        end else if (MASTER_CLEAR_PIN_IN) begin
            filt_q    <= 8'h00;
            pin_low_q <= 1'b0;
        end else if (filt_q >= 8'(FILTER_COUNT)) begin
            pin_low_q <= 1'b1; // RULE12
        end else begin
            filt_q <= filt_q + 8'h01;
        end
    end

    // ****************************************************************
    // Start-up sequence
    // ****************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_HOLD;
            cnt_q   <= 32'h0;
        end else if (bo_trip | lp_trip | por_evt) begin
            state_q <= ST_HOLD; // RULE25
            cnt_q   <= 32'h0;
        end else if (core_evt) begin
            state_q <= ST_START;
            cnt_q   <= 32'h0;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    if (!wait_ready | (DETECTOR_READY & !SUPPLY_LOW)) begin
                        state_q <= ST_POWERUP_TIMER; // RULE1
                    end
                    cnt_q <= 32'h0;
                end
                ST_POWERUP_TIMER: begin
                    // Timer runs regardless of the pin level.
                    if (POWERUP_TIMER_ENABLE_N | cnt_q >= 32'(POWERUP_TIMER_COUNT - 1)) begin
                        state_q <= ST_START; // RULE23 RULE18 RULE19
                        cnt_q   <= 32'h0;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                ST_START: begin
                    if (pin_evt) begin
                        cnt_q <= 32'h0;
                    end else if (cnt_q >= 32'(reset_pkg::PIN_START_CYCLES - 1)) begin
                        state_q <= ST_RUN; // RULE19
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                ST_RUN: begin
                    if (pin_evt) begin
                        state_q <= ST_START; // RULE12
                        cnt_q   <= 32'h0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sw_en_q <= reset_pkg::SW_EN_RESET;
            fast_q  <= reset_pkg::FAST_START_RESET;
        end else if (WR && ADDR == reset_pkg::ADDR_BROWNOUT_CONTROL) begin
            sw_en_q <= WDATA[reset_pkg::BIT_SW_EN]; // RULE6
            fast_q  <= WDATA[reset_pkg::BIT_FAST_START];
        end
    end

    // Cause flags: hardware events win over software writes in the same cycle.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            power_control_q   <= reset_pkg::POWER_CONTROL_POR_VALUE; // RULE21
            status_q <= reset_pkg::STATUS_POR[4:3];
        end else if (por_evt) begin
            power_control_q   <= reset_pkg::POWER_CONTROL_POR_VALUE; // RULE17
            status_q <= reset_pkg::STATUS_POR[4:3];
        end else begin
            if (WR && ADDR == reset_pkg::ADDR_POWER_CONTROL) begin
                power_control_q <= WDATA; // RULE26
            end
            if (WR && ADDR == reset_pkg::ADDR_STATUS) begin
                status_q <= {WDATA[reset_pkg::BIT_TIMEOUT_N], WDATA[reset_pkg::BIT_POWERDOWN_N]};
            end
            if (bo_trip | lp_trip) begin
                power_control_q[reset_pkg::BIT_STACK_OVER]  <= 1'b0; // RULE21 RULE9
                power_control_q[reset_pkg::BIT_STACK_UNDER] <= 1'b0;
                power_control_q[reset_pkg::BIT_PIN_N]       <= 1'b1;
                power_control_q[reset_pkg::BIT_INSTR_N]     <= 1'b1;
                power_control_q[reset_pkg::BIT_BROWNOUT_N]  <= 1'b0;
                status_q    <= 2'b11;
            end else begin
                if (WATCHDOG_OVERFLOW) begin
                    power_control_q[reset_pkg::BIT_WATCHDOG_N] <= 1'b0; // RULE14
                    status_q[1] <= 1'b0;
                end
                if (WATCHDOG_WINDOW) begin
                    power_control_q[reset_pkg::BIT_WINDOW_N] <= 1'b0; // RULE14
                    status_q[1] <= 1'b1;
                end
                if (WAKE_WATCHDOG) begin
                    status_q <= 2'b00; // RULE22
                end else if (WAKE_IRQ) begin
                    status_q <= 2'b10; // RULE22
                end
                if (pin_evt & state_q == ST_RUN) begin
                    power_control_q[reset_pkg::BIT_PIN_N] <= 1'b0; // RULE22
                    if (SLEEPING) begin
                        status_q <= 2'b10;
                    end
                end
                if (RESET_INSTR) begin
                    power_control_q[reset_pkg::BIT_INSTR_N] <= 1'b0; // RULE15
                end
                if (STACK_RESET_ENABLE_CFG & STACK_OVER) begin
                    power_control_q[reset_pkg::BIT_STACK_OVER] <= 1'b1; // RULE16
                end
                if (STACK_RESET_ENABLE_CFG & STACK_UNDER) begin
                    power_control_q[reset_pkg::BIT_STACK_UNDER] <= 1'b1; // RULE16
                end
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                reset_pkg::ADDR_BROWNOUT_CONTROL:
                    RDATA <= {sw_en_q, fast_q, 5'h00, det_on & DETECTOR_READY}; // RULE8
                reset_pkg::ADDR_POWER_CONTROL: RDATA <= power_control_q;
                reset_pkg::ADDR_STATUS:        RDATA <= {3'h0, status_q, 3'h0};
                default:                       RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CORE_RESET       <= 1'b1;
            DETECTOR_ENABLE  <= 1'b0;
            BANDGAP_FORCE_ON <= 1'b0;
            WAKE_HOLD        <= 1'b0;
            PIN_GPIO_IN      <= 1'b1;
            PIN_PULLUP_EN    <= 1'b1;
            PC_LOAD          <= 1'b0;
            PC_VALUE         <= reset_pkg::PC_RESET;
        end else begin
            CORE_RESET      <= (state_q != ST_RUN) | bo_trip | lp_trip | core_evt; // RULE25
            DETECTOR_ENABLE <= det_on;
            BANDGAP_FORCE_ON <= fast_q & (mode_sw
                              | BROWNOUT_MODE_CFG == reset_pkg::MODE_SLEEP_OFF); // RULE7
            WAKE_HOLD       <= BROWNOUT_MODE_CFG == reset_pkg::MODE_SLEEP_OFF
                               & !DETECTOR_READY; // RULE2
            PIN_GPIO_IN     <= pin_en ? 1'b1 : MASTER_CLEAR_PIN_IN; // RULE13
            PIN_PULLUP_EN   <= pin_en | PIN_PULLUP_SW; // RULE13
            PC_LOAD         <= (state_q != ST_RUN) | WAKE_WATCHDOG | WAKE_IRQ;
            if (state_q != ST_RUN) begin
                PC_VALUE <= reset_pkg::PC_RESET; // RULE20
            end else if (WAKE_IRQ & GLOBAL_IRQ_ENABLE) begin
                PC_VALUE <= reset_pkg::PC_VECTOR; // RULE20
            end else if (WAKE_WATCHDOG | WAKE_IRQ) begin
                // Between loads the value holds, so a late sample still sees the last load.
                PC_VALUE <= PC_CURRENT + 15'h1; // RULE20
            end
        end
    end
endmodule
`default_nettype wire

// File: reset_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Reset sequencing checks.
// ************
module reset_ctrl_sva #(
    parameter int POWERUP_TIMER_COUNT   = 20,
    parameter int FILTER_COUNT = 4
) (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic [1:0] BROWNOUT_MODE_CFG,
    input wire logic       LOW_POWER_BROWNOUT_CFG_N,
    input wire logic       MASTER_CLEAR_ENABLE_CFG,
    input wire logic       LOW_VOLTAGE_PROGRAM_CFG,
    input wire logic       SUPPLY_LOW,
    input wire logic       LP_SUPPLY_LOW,
    input wire logic       MASTER_CLEAR_PIN_IN,
    input wire logic       SLEEPING,
    input wire logic       CORE_RESET,
    input wire logic       DETECTOR_ENABLE,
    input wire logic       BANDGAP_FORCE_ON,
    input wire logic       PIN_GPIO_IN
);
    wire logic       en = MASTER_CLEAR_ENABLE_CFG | LOW_VOLTAGE_PROGRAM_CFG;
    wire logic [1:0] m  = BROWNOUT_MODE_CFG;
    wire logic       p  = MASTER_CLEAR_PIN_IN;
    logic [4:0]      hi_q;
    logic [4:0]      lo_q;
    // Both counters saturate, so a long quiet pin never wraps below the bounds.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hi_q <= 5'h00;
            lo_q <= 5'h00;
        end else begin
            hi_q <= p ? hi_q + 5'(~&hi_q) : 5'h00;
            lo_q <= (en && !p) ? lo_q + 5'(~&lo_q) : 5'h00;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_glitch;
        (!CORE_RESET && en && p) ##1 (!p) [*2] ##1 p;
    endsequence
    property p_gap; m[1] == m[0] ##1 m[1] == m[0] |-> !BANDGAP_FORCE_ON; endproperty
    a_gap: assert property (p_gap) else $error("band gap forced");
    property p_on; m == 2'h3 ##1 m == 2'h3 |-> DETECTOR_ENABLE; endproperty
    a_on: assert property (p_on) else $error("detector off");
    property p_slp; (m == 2'h2 && SLEEPING) [*2] |-> !DETECTOR_ENABLE; endproperty
    a_slp: assert property (p_slp) else $error("detector on in sleep");
    property p_gpio; (!en && $stable(p)) [*3] |-> PIN_GPIO_IN == p; endproperty
    a_gpio: assert property (p_gpio) else $error("pin input wrong");
    property p_hold; lo_q > 5'(FILTER_COUNT + 4) |-> CORE_RESET; endproperty
    a_hold: assert property (p_hold) else $error("pin low ignored");
    property p_glitch; s_glitch |=> (!CORE_RESET) [*3]; endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse reset");
    property p_start; $fell(CORE_RESET) && en |-> hi_q >= 5'h0a; endproperty
    a_start: assert property (p_start) else $error("early start");
    property p_bo; (m == 2'h3 && SUPPLY_LOW) [*4] |=> CORE_RESET; endproperty
    a_bo: assert property (p_bo) else $error("brownout ignored");
    property p_lp; (!LOW_POWER_BROWNOUT_CFG_N && LP_SUPPLY_LOW) [*4] |=> CORE_RESET; endproperty
    a_lp: assert property (p_lp) else $error("low power brownout ignored");
endmodule
bind reset_ctrl reset_ctrl_sva #(
    .POWERUP_TIMER_COUNT  (POWERUP_TIMER_COUNT),
    .FILTER_COUNT(FILTER_COUNT)
) u_reset_ctrl_sva (
    .CLK                     (CLK),
    .RSTN                    (RSTN),
    .BROWNOUT_MODE_CFG       (BROWNOUT_MODE_CFG),
    .LOW_POWER_BROWNOUT_CFG_N(LOW_POWER_BROWNOUT_CFG_N),
    .MASTER_CLEAR_ENABLE_CFG (MASTER_CLEAR_ENABLE_CFG),
    .LOW_VOLTAGE_PROGRAM_CFG (LOW_VOLTAGE_PROGRAM_CFG),
    .SUPPLY_LOW              (SUPPLY_LOW),
    .LP_SUPPLY_LOW           (LP_SUPPLY_LOW),
    .MASTER_CLEAR_PIN_IN     (MASTER_CLEAR_PIN_IN),
    .SLEEPING                (SLEEPING),
    .CORE_RESET              (CORE_RESET),
    .DETECTOR_ENABLE         (DETECTOR_ENABLE),
    .BANDGAP_FORCE_ON        (BANDGAP_FORCE_ON),
    .PIN_GPIO_IN             (PIN_GPIO_IN)
);
`default_nettype wire

// File: reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_ctrl_tb;
    logic        clk, rstn, lp_n, clr_en, low_voltage_program_cfg, powerup_timer_n, stk_en, slow, pull_sw, sleeping, global_irq_enable;
    logic        wr, rd, rst, det_en, gap_on, w_hold, gpio, pull_en, pc_load, ready, pin;
    logic [1:0]  mode, addr;
    logic [10:0] act;
    logic [7:0]  wdata, rdata;
    logic [14:0] pc_val, pc_cur;
    int          errors, samples_checked;
    reset_ctrl #(.POWERUP_TIMER_COUNT(20), .FILTER_COUNT(4)) u_reset_ctrl (
        .CLK(clk), .RSTN(rstn), .BROWNOUT_MODE_CFG(mode), .LOW_POWER_BROWNOUT_CFG_N(lp_n),
        .MASTER_CLEAR_ENABLE_CFG(clr_en), .LOW_VOLTAGE_PROGRAM_CFG(low_voltage_program_cfg),
        .POWERUP_TIMER_ENABLE_N(powerup_timer_n), .STACK_RESET_ENABLE_CFG(stk_en), .SUPPLY_LOW(act[8]),
        .LP_SUPPLY_LOW(act[9]), .DETECTOR_READY(ready), .MASTER_CLEAR_PIN_IN(pin),
        .PIN_PULLUP_SW(pull_sw), .PROG_MODE(act[10]), .SLEEPING(sleeping), .WAKE_WATCHDOG(act[5]),
        .WAKE_IRQ(act[6]), .GLOBAL_IRQ_ENABLE(global_irq_enable), .WATCHDOG_OVERFLOW(act[0]),
        .WATCHDOG_WINDOW(act[1]), .RESET_INSTR(act[2]), .STACK_OVER(act[3]),
        .STACK_UNDER(act[4]), .PC_CURRENT(pc_cur), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CORE_RESET(rst), .DETECTOR_ENABLE(det_en),
        .BANDGAP_FORCE_ON(gap_on), .WAKE_HOLD(w_hold), .PIN_GPIO_IN(gpio),
        .PIN_PULLUP_EN(pull_en), .PC_LOAD(pc_load), .PC_VALUE(pc_val));
    supply_model u_supply_model (.clk(clk), .det_en(det_en), .low_req(act[7]), .slow(slow),
        .ready(ready), .pin(pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic wt(input logic v);
        for (int n = 0; n < 300 && rst !== v; n++)
            @(negedge clk);
        chk(rst, v);
    endtask
    task automatic hold(input int i, input int n);
        @(posedge clk);
        act <= 11'(1 << i);
        repeat (n) @(posedge clk);
        act <= 11'h000;
        @(negedge clk);
    endtask
    task automatic rst_by(input int i, input int n, input logic [7:0] power_control);
        hold(i, n);
        wt(1'b1);
        wt(1'b0);
        rchk(2'h1, power_control);
    endtask
    task automatic wake(input int i, input logic g, input logic [14:0] pc, input logic [7:0] st);
        @(posedge clk);
        sleeping <= 1'b1;
        global_irq_enable <= g;
        hold(i, 1);
        for (int n = 0; n < 50 && pc_load !== 1'b1; n++)
            @(negedge clk);
        chk({pc_load, pc_val}, {1'b1, pc});
        @(posedge clk);
        sleeping <= 1'b0;
        rchk(2'h2, st);
    endtask
    task automatic t_regs;
        repeat (30) @(negedge clk);
        chk({rst, pc_load}, 2'b11);
        wt(1'b0);
        chk(pc_val, reset_pkg::PC_RESET);
        rchk(2'h0, 8'h81);
        rchk(2'h1, reset_pkg::POWER_CONTROL_POR_VALUE);
        rchk(2'h2, 8'h18);
        wreg(2'h0, 8'hff);
        rchk(2'h0, 8'hc1);
        wreg(2'h3, 8'hff);
        rchk(2'h3, 8'h00);
        $display("registers done");
    endtask
    task automatic t_causes;
        rst_by(2, 1, 8'h38);
        rst_by(0, 1, 8'h28);
        rchk(2'h2, 8'h08);
        rst_by(1, 1, 8'h08);
        rchk(2'h2, 8'h18);
        rst_by(3, 1, 8'h88);
        @(posedge clk);
        stk_en <= 1'b0;
        hold(3, 1);
        repeat (6) @(negedge clk);
        chk(rst, 1'b0);
        @(posedge clk);
        stk_en <= 1'b1;
        rst_by(4, 1, 8'hc8);
        rst_by(7, 12, 8'hc0);
        hold(7, 2);
        repeat (6) @(negedge clk);
        chk(rst, 1'b0);
        rst_by(8, 6, 8'h0c);
        rst_by(10, 4, 8'h3c);
        rchk(2'h2, 8'h18);
        $display("causes done");
    endtask
    task automatic t_modes;
        wreg(2'h1, 8'h2d);
        rchk(2'h1, 8'h2d);
        @(posedge clk);
        mode <= 2'h1;
        slow <= 1'b0;
        wreg(2'h0, 8'h40);
        repeat (12) @(negedge clk);
        chk({det_en, gap_on}, 2'b01);
        rchk(2'h0, 8'h40);
        wreg(2'h0, 8'h80);
        sleeping <= 1'b1;
        repeat (12) @(negedge clk);
        chk({det_en, gap_on}, 2'b10);
        rchk(2'h0, 8'h81);
        @(posedge clk);
        mode <= 2'h2;
        repeat (4) @(negedge clk);
        chk({det_en, w_hold}, 2'b01);
        @(posedge clk);
        {sleeping, mode, lp_n} <= 4'h0;
        rst_by(9, 6, 8'h2c);
        $display("modes done");
    endtask
    task automatic t_pin;
        @(posedge clk);
        {clr_en, pull_sw, act} <= 13'h0080;
        repeat (12) @(negedge clk);
        chk({rst, gpio, pull_en}, 3'b000);
        @(posedge clk);
        pull_sw <= 1'b1;
        repeat (4) @(negedge clk);
        chk(pull_en, 1'b1);
        @(posedge clk);
        low_voltage_program_cfg <= 1'b1;
        repeat (12) @(negedge clk);
        chk(rst, 1'b1);
        @(posedge clk);
        {low_voltage_program_cfg, clr_en, pull_sw, act} <= 14'h1800;
        wt(1'b0);
        wake(6, 1'b1, reset_pkg::PC_VECTOR, 8'h10);
        @(posedge clk);
        pc_cur <= 15'h0200;
        wake(5, 1'b0, 15'h0201, 8'h00);
        $display("pin and wake done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        errors++;
        conclude();
    end
    initial begin
        {lp_n, clr_en, slow, pull_sw, stk_en} = 5'h1f;
        {low_voltage_program_cfg, powerup_timer_n, sleeping, global_irq_enable, wr, rd, rstn} = 7'h00;
        {mode, addr, act, wdata} = 23'h600000;
        pc_cur = 15'h0100;
        errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_causes();
        t_modes();
        t_pin();
        conclude();
    end
endmodule
`default_nettype wire

// File: reset_pkg.sv
// Summary of operation
// RULE1: Mode 10 keeps detection on awake, off in sleep; start-up waits for ready and supply.
// RULE2: Mode 10 holds sleep wake-up until the detector reports ready.
// RULE3: Mode 01 lets software enable switch detection; start-up does not wait.
// RULE4: Software-controlled protection acts only once ready; ready bit mirrors readiness.
// RULE5: Software-controlled protection is unchanged by entering or leaving sleep.
// RULE6: Bit 7 enables detection in mode 01 only; otherwise plain storage.
// RULE7: Bit 6 forces band gap on in modes 10 and 01; no effect otherwise.
// RULE8: Bit 0 reads detector active; bits 5 to 1 read zero.
// RULE9: Low-power detector low supply holds reset and clears the brownout flag.
// RULE10: Low-power detector enabled by active-low config bit; erased means disabled.
// RULE11: Pin reset disabled only when pin enable and low-voltage program bits are 0.
// RULE12: Enabled pin low holds reset, short pulses filtered, never driven low.
// RULE13: Disabled pin is a general input with software pull-up.
// RULE14: Watchdog overflow clears timeout flag; window violation clears violation flag.
// RULE15: Reset instruction resets and clears its flag, other flags unchanged.
// RULE16: Stack fault resets only when enabled and sets its own flag.
// RULE17: Leaving programming mode acts exactly like power-on reset; here brownout control bits 7 and 6 keep their values.
// RULE18: Execution waits for power-up timer expiry, then pin release.
// RULE19: Timer runs independent of pin; start 10 clocks after late pin release.
// RULE20: Reset loads PC 0000h; wake continues PC+1, vectors 0004h on enabled interrupt.
// RULE21: Power-on gives control 0011 110x, status 1 1000; brownout 00uu 11u0, 1 1uuu.
// RULE22: Power-on sets timeout and powerdown; wake and pin resets update them.
// RULE23: Power-up timer gives 64 ms hold, enabled by active-low config bit.
// RULE24: Mode 11 always on including sleep; start-up waits; wake not delayed.
// RULE25: Reset sources are combined and released synchronously on a clock edge.
// RULE26: Cause flags keep values across unrelated resets; software can re-arm them.
`default_nettype none
package reset_pkg;
    localparam logic [1:0] ADDR_BROWNOUT_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_POWER_CONTROL    = 2'h1;
    localparam logic [1:0] ADDR_STATUS           = 2'h2;
    localparam int BIT_SW_EN      = 7;
    localparam int BIT_FAST_START = 6;
    localparam int BIT_READY      = 0;
    localparam int BIT_STACK_OVER  = 7;
    localparam int BIT_STACK_UNDER = 6;
    localparam int BIT_WINDOW_N    = 5;
    localparam int BIT_WATCHDOG_N  = 4;
    localparam int BIT_PIN_N       = 3;
    localparam int BIT_INSTR_N     = 2;
    localparam int BIT_BROWNOUT_N  = 0;
    localparam int BIT_TIMEOUT_N   = 4;
    localparam int BIT_POWERDOWN_N = 3;
    localparam logic       SW_EN_RESET      = 1'b1;
    localparam logic       FAST_START_RESET = 1'b0;
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
    localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
    localparam logic [1:0] MODE_SOFTWARE  = 2'h1;
    localparam logic [7:0] POWER_CONTROL_POR_VALUE = 8'h3c;
    localparam logic [4:0] STATUS_POR     = 5'h18;
    localparam logic [14:0] PC_RESET  = 15'h0000;
    localparam logic [14:0] PC_VECTOR = 15'h0004;
    localparam int  CLK_HZ           = 50000000;
    localparam int  POWERUP_TIMER_MS          = 64;
    localparam int  POWERUP_TIMER_CYCLES      = (CLK_HZ / 1000) * POWERUP_TIMER_MS;
    localparam int  PIN_START_CYCLES = 10;
    localparam int  PIN_FILTER_CYCLES = 4;
endpackage
`default_nettype wire

// File: supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Supply monitor and reset pin driver.
// ************
module supply_model (
    input  wire logic clk,
    input  wire logic det_en,
    input  wire logic low_req,
    input  wire logic slow,
    output logic      ready,
    output logic      pin
);
    logic [3:0] warm_q = 4'h0;
    // The driver only pulls low; once released the weak pull-up returns the pin high.
    assign pin = !low_req;
    // Readiness needs a warm-up after enable and drops as soon as the detector is off.
    always @(posedge clk) begin
        if (!det_en)
            warm_q <= 4'h0;
        else if (warm_q != 4'hf)
            warm_q <= warm_q + 4'h1;
    end
    assign ready = det_en && (warm_q > (slow ? 4'h8 : 4'h1));
endmodule
`default_nettype wire
